//--- logic/uart_status_flags.sv
// Async serial transceiver with status flags and APB register slave
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps

// What this block does
// - Status register is read-only; writes to it change nothing.
// - Parity error flag set on failed parity check, only with parity on.
// - Status read then data access clears parity, noise, framing, overrun.
// - Noise flag set with receive-available; never for an overrun character.
// - Overrun sets on full buffer and blocks later transfers while set.
// - Receiver idle low from start detect to stop-bit centre, else high.
// - Character into data register sets receive-available; interrupt if enabled.
// - Noise, framing, parity flags set in same cycle as receive-available.
// - Receive-available clears after status read, data read, buffer empty.
// - Transmitter idle only with holding empty and nothing shifting out.
// - Transmit line high while transmitter idle flag is set.
// - Status read with idle set then data write clears transmitter idle.
// - Transmitter idle not set while character or break is queued.
// - Holding-empty set when character moves into the shift register.
// - Status read with holding-empty set then data write clears it.
// - Enabling the transmitter sets holding-empty.
// - One data address: writes transmit, reads return received data.
// - Bit rate comes from a separate 8-bit divisor register.
// - Received characters wait in a two-entry buffer.
// - Characters travel least significant bit first.
// - Disable clears error flags and receive-available, sets idle flags.
// - Break: finish buffered data, then line low 13+ bits until cleared.
module uart_status_flags (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire uart_status_flags_pkg::apb_req_s apb_req,
   output uart_status_flags_pkg::apb_rsp_s apb_rsp,
   input wire logic rx_pin,
   output logic tx_line,
   output logic tx_oe_n,
   output logic rx_irq
);
   import uart_status_flags_pkg::*;

   logic [7:0] ctl1_q, ctl2_q, baud_q, rd_mux;
   logic parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, receiver_idle_flag_q, receive_data_available_q, transmitter_idle_flag_q, transmit_holding_empty_q;
   logic err_arm_q, rx_arm_q, transmit_holding_empty_arm_q, transmitter_idle_flag_arm_q, mapped;
   logic irq_q, line_q, oe_n_q;
   apb_rsp_s rsp_q;
   status_s st;
   logic [8:0] rx_mem_q [RX_DEPTH];
   logic rx_head_q;
   logic [1:0] rx_cnt_q;

   assign st = {parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, receiver_idle_flag_q, receive_data_available_q, transmitter_idle_flag_q,
      transmit_holding_empty_q};

   ////////////////////////////////////////////////////////////////////
   // Register bus
   wire en = ctl1_q[EN_BIT];
   wire acc = clk_en & apb_req.psel & apb_req.penable & ~rsp_q.pready;
   wire wr = acc & apb_req.pwrite;
   wire rd = acc & ~apb_req.pwrite;
   wire st_rd = rd & (apb_req.paddr == STATUS_OFS);
   wire data_acc = acc & (apb_req.paddr == DATA_OFS);
   wire data_rd = data_acc & ~apb_req.pwrite;
   wire data_wr = data_acc & apb_req.pwrite;
   wire [8:0] rx_head = rx_mem_q[rx_head_q];

   always_comb begin
      mapped = 1'b1;
      case (apb_req.paddr)
         STATUS_OFS: rd_mux = st;
         CTRL1_OFS: rd_mux = {ctl1_q[7:2], rx_head[8], 1'b0};
         CTRL2_OFS: rd_mux = ctl2_q;
         DATA_OFS: rd_mux = rx_head[7:0];
         BAUD_OFS: rd_mux = baud_q;
         default: begin
            rd_mux = 8'h00;
            mapped = 1'b0;
         end
      endcase
   end

   // One wait state: side effects land at the edge before pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_q <= '0;
      end else if (clk_en) begin
         rsp_q.pready <= acc;
         if (acc) begin
            rsp_q.pslverr <= ~mapped;
            rsp_q.prdata <= apb_req.pwrite ? 32'h0 : {24'h0, rd_mux};
         end
      end
   end

   // Status offset has no write path at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1_q <= CTRL_RST;
         ctl2_q <= CTRL_RST;
         baud_q <= BAUD_RST;
      end else if (clk_en) begin
         if (wr && apb_req.paddr == CTRL1_OFS) begin
            ctl1_q <= apb_req.pwdata[7:0];
         end else if (!en) begin
            ctl1_q[BRK_BIT] <= 1'b0;
         end
         if (wr && apb_req.paddr == CTRL2_OFS) begin
            ctl2_q <= apb_req.pwdata[7:0];
         end else if (!en) begin
            ctl2_q[TRANSMITTER_ENABLE_BIT] <= 1'b0;
            ctl2_q[RECEIVER_ENABLE_BIT] <= 1'b0;
         end
         if (wr && apb_req.paddr == BAUD_OFS) begin
            baud_q <= apb_req.pwdata[7:0];
         end
      end
   end

   // Status read arms the clears that the next data access performs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_arm_q <= 1'b0;
         rx_arm_q <= 1'b0;
         transmit_holding_empty_arm_q <= 1'b0;
         transmitter_idle_flag_arm_q <= 1'b0;
      end else if (st_rd) begin
         err_arm_q <= 1'b1;
         rx_arm_q <= receive_data_available_q;
         transmit_holding_empty_arm_q <= transmit_holding_empty_q;
         transmitter_idle_flag_arm_q <= transmitter_idle_flag_q;
      end else begin
         if (data_acc) begin
            err_arm_q <= 1'b0;
         end
         if (data_rd) begin
            rx_arm_q <= 1'b0;
         end
         if (data_wr) begin
            transmit_holding_empty_arm_q <= 1'b0;
            transmitter_idle_flag_arm_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Baud tick: sixteen per bit
   logic [9:0] pre_q;
   wire [9:0] pre_top = ctl2_q[HS_BIT] ? {2'b00, baud_q} : {baud_q, LOW_PAD};
   wire tick = clk_en & en & (pre_q == pre_top);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
      end else if (clk_en) begin
         if (!en || tick) begin
            pre_q <= '0;
         end else begin
            pre_q <= pre_q + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Receiver
   logic rx_s1_q, rx_s2_q, rx_par_q, rx_nz_q;
   logic [3:0] rx_ovs_q, rx_bit_q;
   logic [8:0] rx_sh_q;
   logic [1:0] rx_smp_q;
   rx_state_e rx_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_s1_q <= 1'b1;
         rx_s2_q <= 1'b1;
      end else if (clk_en) begin
         rx_s1_q <= rx_pin;
         rx_s2_q <= rx_s1_q;
      end
   end

   wire rx_run = en & ctl2_q[RECEIVER_ENABLE_BIT];
   wire nine = ctl1_q[NINE_BIT];
   wire [3:0] n_bits = nine ? BITS9 : BITS8;
   wire maj = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_s2_q) |
      (rx_smp_q[1] & rx_s2_q);
   wire nz = (rx_smp_q[0] != rx_s2_q) | (rx_smp_q[1] != rx_s2_q);
   wire mid = tick & (rx_ovs_q == MID_C);
   // Gated so a receiver switched off at the stop centre stores nothing
   wire rx_done = mid & (rx_q == RX_STOP) & rx_run;
   wire pe_ev = ctl1_q[PAR_BIT] & (rx_par_q ^ ctl1_q[ODD_BIT]);
   wire [8:0] rx_all = nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
   wire [8:0] rx_word = ctl1_q[PAR_BIT] ? rx_all & (nine ? MASK9 : MASK8)
      : rx_all;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q <= RX_IDLE;
         receiver_idle_flag_q <= STATUS_RST.receiver_idle_flag;
         rx_ovs_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q <= '0;
         rx_smp_q <= '0;
         rx_par_q <= 1'b0;
         rx_nz_q <= 1'b0;
      end else if (clk_en) begin
         if (!rx_run) begin
            rx_q <= RX_IDLE;
            receiver_idle_flag_q <= 1'b1;
         end else if (tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            if (rx_ovs_q == MID_A) begin
               rx_smp_q[0] <= rx_s2_q;
            end
            if (rx_ovs_q == MID_B) begin
               rx_smp_q[1] <= rx_s2_q;
            end
            case (rx_q)
               RX_IDLE: if (!rx_s2_q) begin
                  rx_q <= RX_START;
                  receiver_idle_flag_q <= 1'b0;
                  rx_ovs_q <= '0;
                  rx_bit_q <= '0;
                  rx_par_q <= 1'b0;
                  rx_nz_q <= 1'b0;
               end
               RX_START: if (mid && maj) begin
                  rx_q <= RX_IDLE;
                  receiver_idle_flag_q <= 1'b1;
               end else if (rx_ovs_q == OVS_LAST) begin
                  rx_q <= RX_DATA;
               end
               RX_DATA: begin
                  if (mid) begin
                     rx_sh_q <= {maj, rx_sh_q[8:1]};
                     rx_par_q <= rx_par_q ^ maj;
                     rx_nz_q <= rx_nz_q | nz;
                  end
                  if (rx_ovs_q == OVS_LAST) begin
                     if (rx_bit_q == n_bits - 4'h1) begin
                        rx_q <= RX_STOP;
                     end else begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                     end
                  end
               end
               RX_STOP: if (mid) begin
                  rx_q <= RX_IDLE;
                  receiver_idle_flag_q <= 1'b1;
               end
               default: rx_q <= RX_IDLE;
            endcase
         end
      end
   end

   // Buffer refuses new words while overrun stands, even with room
   wire push = rx_done & ~overrun_flag_q & (rx_cnt_q != RX_FULL);
   wire ovr = rx_done & (rx_cnt_q == RX_FULL);
   wire pop = data_rd & (rx_cnt_q != 2'h0);
   wire clr_err = data_acc & err_arm_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_head_q <= 1'b0;
         rx_cnt_q <= '0;
         rx_mem_q <= '{default: '0};
      end else if (clk_en) begin
         if (!rx_run) begin
            rx_head_q <= 1'b0;
            rx_cnt_q <= '0;
         end else begin
            if (push) begin
               rx_mem_q[rx_head_q ^ rx_cnt_q[0]] <= rx_word;
            end
            if (pop) begin
               rx_head_q <= ~rx_head_q;
            end
            rx_cnt_q <= rx_cnt_q + {1'b0, push} - {1'b0, pop};
         end
      end
   end

   // Set terms win over the software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parity_error_flag_q <= STATUS_RST.parity_error_flag;
         nf_q <= STATUS_RST.nf;
         framing_error_flag_q <= STATUS_RST.framing_error_flag;
         overrun_flag_q <= STATUS_RST.overrun_flag;
         receive_data_available_q <= STATUS_RST.receive_data_available;
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= receive_data_available_q & ctl2_q[RIE_BIT];
         if (!en) begin
            parity_error_flag_q <= 1'b0;
            nf_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
            overrun_flag_q <= 1'b0;
            receive_data_available_q <= 1'b0;
         end else begin
            parity_error_flag_q <= (push & pe_ev) | (parity_error_flag_q & ~clr_err);
            nf_q <= (push & (rx_nz_q | nz)) | (nf_q & ~clr_err);
            framing_error_flag_q <= (push & ~maj) | (framing_error_flag_q & ~clr_err);
            overrun_flag_q <= ovr | (overrun_flag_q & ~clr_err);
            receive_data_available_q <= push | (receive_data_available_q & rx_run &
               ~(rx_arm_q & pop & (rx_cnt_q == 2'h1)));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transmitter
   logic [8:0] thr_q, tx_sh_q;
   logic thr_full_q, tx_par_q;
   logic [3:0] tx_ovs_q, tx_bit_q;
   tx_state_e tx_q;

   wire tx_run = en & ctl2_q[TRANSMITTER_ENABLE_BIT];
   wire brk = ctl1_q[BRK_BIT];
   wire tx_load = tx_run & thr_full_q & (tx_q == TX_IDLE);
   wire bit_end = tick & (tx_ovs_q == OVS_LAST);
   wire tx_last = tx_bit_q == n_bits - 4'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_q <= '0;
         thr_full_q <= 1'b0;
      end else if (clk_en) begin
         if (!tx_run) begin
            thr_full_q <= 1'b0;
         end else if (data_wr) begin
            thr_q <= {ctl1_q[TX8_BIT], apb_req.pwdata[7:0]};
            thr_full_q <= 1'b1;
         end else if (tx_load) begin
            thr_full_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_q <= TX_IDLE;
         tx_ovs_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q <= '0;
         tx_par_q <= 1'b0;
         line_q <= 1'b1;
         oe_n_q <= 1'b1;
      end else if (clk_en) begin
         oe_n_q <= ~tx_run;
         if (tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
         end
         if (!tx_run) begin
            tx_q <= TX_IDLE;
            line_q <= 1'b1;
         end else begin
            case (tx_q)
               TX_IDLE: begin
                  line_q <= 1'b1;
                  tx_ovs_q <= '0;
                  tx_bit_q <= '0;
                  tx_par_q <= 1'b0;
                  // Buffered data goes first, the break waits
                  if (tx_load) begin
                     tx_q <= TX_START;
                     tx_sh_q <= thr_q;
                  end else if (brk) begin
                     tx_q <= TX_BRK;
                  end
               end
               TX_START: begin
                  line_q <= 1'b0;
                  if (bit_end) begin
                     tx_q <= TX_DATA;
                  end
               end
               TX_DATA: begin
                  line_q <= (tx_last && ctl1_q[PAR_BIT]) ?
                     tx_par_q ^ ctl1_q[ODD_BIT] : tx_sh_q[0];
                  if (bit_end) begin
                     tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                     tx_par_q <= tx_par_q ^ tx_sh_q[0];
                     tx_bit_q <= tx_last ? 4'h0 : tx_bit_q + 4'h1;
                     if (tx_last) begin
                        tx_q <= TX_STOP;
                     end
                  end
               end
               TX_STOP: begin
                  line_q <= 1'b1;
                  if (bit_end) begin
                     if (ctl1_q[STOP2_BIT] && tx_bit_q == 4'h0) begin
                        tx_bit_q <= 4'h1;
                     end else begin
                        tx_q <= TX_IDLE;
                     end
                  end
               end
               TX_BRK: begin
                  line_q <= 1'b0;
                  if (bit_end && tx_bit_q != BRK_BITS) begin
                     tx_bit_q <= tx_bit_q + 4'h1;
                  end
                  if (tx_bit_q == BRK_BITS && !brk) begin
                     tx_q <= TX_IDLE;
                  end
               end
               default: tx_q <= TX_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_holding_empty_q <= STATUS_RST.transmit_holding_empty;
         transmitter_idle_flag_q <= STATUS_RST.transmitter_idle_flag;
      end else if (clk_en) begin
         if (!en) begin
            transmit_holding_empty_q <= 1'b1;
            transmitter_idle_flag_q <= 1'b1;
         end else begin
            transmit_holding_empty_q <= tx_load |
               (wr && apb_req.paddr == CTRL2_OFS &&
               apb_req.pwdata[TRANSMITTER_ENABLE_BIT] && !thr_full_q) |
               (transmit_holding_empty_q & ~(data_wr & transmit_holding_empty_arm_q));
            transmitter_idle_flag_q <= transmit_holding_empty_q & (tx_q == TX_IDLE) & ~thr_full_q &
               ~brk & ~data_wr &
               ~(data_wr & transmitter_idle_flag_arm_q);
         end
      end
   end

   assign apb_rsp = rsp_q;
   assign tx_line = line_q;
   assign tx_oe_n = oe_n_q;
   assign rx_irq = irq_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_push_parity_error_flag;
      push && pe_ev;
   endsequence
   sequence s_pop_two;
      pop && rx_cnt_q == RX_FULL && receive_data_available_q && rx_run;
   endsequence
   sequence s_brk_run;
      (tx_q == TX_BRK && clk_en) ##1 (tx_q == TX_BRK);
   endsequence
   sequence s_brk_exit;
      (tx_q == TX_BRK && tx_run) ##1 (tx_q == TX_IDLE && tx_run);
   endsequence

   property p_parity_error_flag_set;
      s_push_parity_error_flag |=> parity_error_flag_q;
   endproperty
   property p_err_clr;
      clr_err && !push && !ovr |=> !(parity_error_flag_q | nf_q | framing_error_flag_q | overrun_flag_q);
   endproperty
   property p_nf_ovr;
      ovr && !nf_q |=> !nf_q;
   endproperty
   property p_ovr_block;
      overrun_flag_q && clk_en |=> rx_cnt_q <= $past(rx_cnt_q);
   endproperty
   property p_receiver_idle_flag;
      rx_q == RX_DATA |-> !receiver_idle_flag_q;
   endproperty
   property p_receive_data_available_set;
      push |=> receive_data_available_q;
   endproperty
   property p_receive_data_available_keep;
      s_pop_two |=> receive_data_available_q;
   endproperty
   property p_transmitter_idle_flag_transmit_holding_empty;
      transmitter_idle_flag_q |-> transmit_holding_empty_q;
   endproperty
   property p_idle_line;
      transmitter_idle_flag_q |-> line_q;
   endproperty
   property p_transmit_holding_empty_load;
      tx_load |=> transmit_holding_empty_q;
   endproperty
   property p_brk_low;
      s_brk_run |-> !line_q;
   endproperty
   property p_brk_len;
      s_brk_exit |-> $past(tx_bit_q) == BRK_BITS;
   endproperty

   a_parity_error_flag_set: assert property (p_parity_error_flag_set)
      else $error("parity error flag not set");
   a_err_clr: assert property (p_err_clr)
      else $error("error flags not cleared");
   a_nf_ovr: assert property (p_nf_ovr)
      else $error("noise flag set on overrun");
   a_ovr_block: assert property (p_ovr_block)
      else $error("transfer during overrun");
   a_receiver_idle_flag: assert property (p_receiver_idle_flag)
      else $error("receiver idle during data");
   a_receive_data_available_set: assert property (p_receive_data_available_set)
      else $error("receive available not set");
   a_receive_data_available_keep: assert property (p_receive_data_available_keep)
      else $error("receive available cleared with data left");
   a_transmitter_idle_flag_transmit_holding_empty: assert property (p_transmitter_idle_flag_transmit_holding_empty)
      else $error("transmitter idle without holding empty");
   a_idle_line: assert property (p_idle_line)
      else $error("line low while transmitter idle");
   a_transmit_holding_empty_load: assert property (p_transmit_holding_empty_load)
      else $error("holding empty not set on load");
   a_brk_low: assert property (p_brk_low)
      else $error("line high during break");
   a_brk_len: assert property (p_brk_len)
      else $error("break ended early");
endmodule

//--- logic/uart_status_flags_pkg.sv
// Register map, field positions, carriers and states of the serial port
package uart_status_flags_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] CTRL1_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] CTRL2_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] DATA_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] BAUD_OFS = 8'h10;
   // control_one fields
   localparam int EN_BIT = 7;
   localparam int NINE_BIT = 6;
   localparam int PAR_BIT = 5;
   localparam int ODD_BIT = 4;
   localparam int STOP2_BIT = 3;
   localparam int BRK_BIT = 2;
   localparam int TX8_BIT = 0;
   // control_two fields
   localparam int TRANSMITTER_ENABLE_BIT = 7;
   localparam int RECEIVER_ENABLE_BIT = 6;
   localparam int HS_BIT = 5;
   localparam int RIE_BIT = 2;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] BAUD_RST = 8'h00;
   // Oversampling: sixteen ticks per bit, three votes near the centre
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] MID_A = 4'h7;
   localparam logic [3:0] MID_B = 4'h8;
   localparam logic [3:0] MID_C = 4'h9;
   localparam logic [1:0] LOW_PAD = 2'h3;
   localparam logic [3:0] BITS8 = 4'h8;
   localparam logic [3:0] BITS9 = 4'h9;
   localparam logic [8:0] MASK8 = 9'h07f;
   localparam logic [8:0] MASK9 = 9'h0ff;
   localparam logic [3:0] BRK_BITS = 4'hd;
   localparam int RX_DEPTH = 2;
   localparam logic [1:0] RX_FULL = 2'h2;

   typedef struct packed {
      logic parity_error_flag;
      logic nf;
      logic framing_error_flag;
      logic overrun_flag;
      logic receiver_idle_flag;
      logic receive_data_available;
      logic transmitter_idle_flag;
      logic transmit_holding_empty;
   } status_s;
   localparam status_s STATUS_RST = 8'h0b;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
   } rx_state_e;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
      TX_STOP = 5'h08, TX_BRK = 5'h10
   } tx_state_e;
endpackage

//--- sim/remote_serial.sv
// Remote serial device model on the far side of the link
`timescale 1ns/10ps
module remote_serial (
   input wire logic pclk,
   output logic rx_pin,
   input wire logic tx_line,
   input wire logic tx_oe_n
);
   localparam int BIT_CLKS = 16;
   logic [7:0] got;
   int n_got;
   initial begin
      rx_pin = 1'b1;
      n_got = 0;
   end
   ////////////////////////////////////////
   // Line rests high between frames
   task automatic send(input logic [8:0] v, input int n, input logic stp,
      input int g);
      rx_pin <= 1'b0;
      repeat (BIT_CLKS) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         rx_pin <= v[i];
         repeat (BIT_CLKS / 2) @(posedge pclk);
         // One-clock glitch in bit g: outvoted, yet reported as noise
         rx_pin <= v[i] ^ (i == g);
         @(posedge pclk);
         rx_pin <= v[i];
         repeat (BIT_CLKS / 2 - 1) @(posedge pclk);
      end
      rx_pin <= stp;
      repeat (BIT_CLKS) @(posedge pclk);
      rx_pin <= 1'b1;
      repeat (BIT_CLKS) @(posedge pclk);
   endtask
   // Centre sampling; stop bit not judged
   always begin
      @(negedge tx_line iff tx_oe_n === 1'b0);
      repeat (BIT_CLKS / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge pclk);
         got[i] = tx_line;
      end
      repeat (BIT_CLKS) @(posedge pclk);
      n_got++;
   end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the serial status flags block
`timescale 1ns/10ps
module testbench;
   import uart_status_flags_pkg::*;
   logic pclk, presetn, clk_en, rx_pin, tx_line, tx_oe_n, rx_irq, slv;
   apb_req_s req;
   apb_rsp_s rsp;
   logic [31:0] r;
   logic [8:0] v;
   logic [7:0] d;
   logic [7:0] w[3];
   int n_errors, tests_run, k;
   uart_status_flags uart_status_flags_i (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp), .rx_pin(rx_pin),
      .tx_line(tx_line), .tx_oe_n(tx_oe_n), .rx_irq(rx_irq));
   remote_serial remote_serial_i (.pclk(pclk), .rx_pin(rx_pin),
      .tx_line(tx_line), .tx_oe_n(tx_oe_n));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Edge first, so release and next setup never share a time step
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [7:0] dd);
      int n;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, wr, a, {24'h0, dd}};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_errors++;
         end_sim();
      end
      r = rsp.prdata;
      slv = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(r, {24'h0, e});
   endtask
   task automatic wait_got(input int k0);
      int j;
      j = 0;
      while (remote_serial_i.n_got == k0 && j < 400) begin
         @(posedge pclk);
         j++;
      end
      if (j >= 400) begin
         n_errors++;
         end_sim();
      end
   endtask
   task automatic done(input string s);
      $display("End of %0s, %0d checks", s, tests_run);
   endtask
   // Status from {parity, framing, overrun, rx available}; idles high
   function automatic logic [7:0] st(input logic [3:0] f);
      return {f[3], 1'b0, f[2], f[1], 1'b1, f[0], 2'b11};
   endfunction
   ////////////////////////////////////////
   initial begin
      req = '0;
      clk_en = 1'b1;
      presetn = 1'b0;
      n_errors = 0;
      tests_run = 0;
      k = $urandom(32'hd5188ac0);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(STATUS_OFS, st(4'h0));
      rdc(CTRL1_OFS, CTRL_RST);
      rdc(CTRL2_OFS, CTRL_RST);
      apb(1'b0, 8'h14, 8'h00);
      chk(32'(slv), 32'h1);
      apb(1'b1, STATUS_OFS, 8'hff);
      rdc(STATUS_OFS, st(4'h0));
      d = 8'($urandom);
      apb(1'b1, BAUD_OFS, d);
      rdc(BAUD_OFS, d);
      apb(1'b1, BAUD_OFS, BAUD_RST);
      apb(1'b1, CTRL1_OFS, 8'h80);
      apb(1'b1, CTRL2_OFS, 8'he4);
      rdc(STATUS_OFS, st(4'h0));
      chk(32'(tx_oe_n), 32'h0);
      done("registers");
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 8'h80 : 8'($urandom);
         rdc(STATUS_OFS, st(4'h0));
         k = remote_serial_i.n_got;
         apb(1'b1, DATA_OFS, d);
         rdc(STATUS_OFS, 8'h09);
         wait_got(k);
         chk(32'(remote_serial_i.got), 32'(d));
         repeat (24) @(posedge pclk);
         rdc(STATUS_OFS, st(4'h0));
         chk(32'(tx_line), 32'h1);
      end
      done("transmit");
      apb(1'b1, CTRL1_OFS, 8'h84);
      repeat (32) @(posedge pclk);
      apb(1'b1, CTRL1_OFS, 8'h80);
      repeat (100) @(posedge pclk);
      chk(32'(tx_line), 32'h0);
      rdc(STATUS_OFS, 8'h09);
      repeat (150) @(posedge pclk);
      rdc(STATUS_OFS, st(4'h0));
      chk(32'(tx_line), 32'h1);
      done("break");
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, CTRL1_OFS, {2'b10, m != 0, m == 2, 4'h0});
         for (int b = 0; b < 2; b++) begin
            d = 8'($urandom);
            v = {1'b0, ^d[6:0] ^ (m == 2) ^ b[0], d[6:0]};
            remote_serial_i.send(v, 8, 1'b1, -1);
            chk(32'(rx_irq), 32'h1);
            rdc(STATUS_OFS, st({m != 0 && b[0], 3'h1}));
            rdc(DATA_OFS, (m != 0) ? {1'b0, v[6:0]} : v[7:0]);
            rdc(STATUS_OFS, st(4'h0));
         end
      end
      done("parity");
      apb(1'b1, CTRL1_OFS, 8'hc0);
      v = 9'($urandom);
      remote_serial_i.send(v, 9, 1'b1, -1);
      rdc(CTRL1_OFS, {6'h30, v[8], 1'b0});
      rdc(STATUS_OFS, st(4'h1));
      rdc(DATA_OFS, v[7:0]);
      done("nine bit");
      apb(1'b1, CTRL1_OFS, 8'h80);
      for (int i = 0; i < 3; i++) begin
         w[i] = 8'($urandom);
         remote_serial_i.send({1'b0, w[i]}, 8, 1'b1, -1);
      end
      rdc(STATUS_OFS, st(4'h3));
      rdc(DATA_OFS, w[0]);
      rdc(STATUS_OFS, st(4'h1));
      rdc(DATA_OFS, w[1]);
      rdc(STATUS_OFS, st(4'h0));
      done("overrun");
      d = 8'($urandom);
      remote_serial_i.send({1'b0, d}, 8, 1'b1, 3);
      rdc(STATUS_OFS, st(4'h1) | 8'h40);
      rdc(DATA_OFS, d);
      rdc(STATUS_OFS, st(4'h0));
      done("noise");
      remote_serial_i.send({1'b0, 8'($urandom)}, 8, 1'b0, -1);
      rdc(STATUS_OFS, st(4'h5));
      apb(1'b1, CTRL1_OFS, 8'h00);
      rdc(STATUS_OFS, st(4'h0));
      rdc(CTRL2_OFS, 8'h24);
      chk(32'(tx_oe_n), 32'h1);
      done("framing and disable");
      end_sim();
   end
endmodule
